// ### baud_if.sv
// Link between the register block and the baud tick generator
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
    logic [15:0] divisor;
    logic        run;
    logic        tick;
    modport ctrl (output divisor, output run, input tick);
    modport gen  (input divisor, input run, output tick);
endinterface : baud_if
`default_nettype wire

// ### baud_tick_gen.sv
// Baud tick divider, sixteen ticks per bit
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen #(
    parameter int WIDTH = 16
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    baud_if.gen       bus
);
    logic [WIDTH-1:0] count;

    // Stopped generator holds no phase, so waking restarts a clean bit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count    <= '0;
            bus.tick <= 1'b0;
        end else if (!bus.run) begin
            count    <= '0;
            bus.tick <= 1'b0;
        end else if (count >= bus.divisor) begin
            count    <= '0;
            bus.tick <= 1'b1;
        end else begin
            count    <= count + 1'b1;
            bus.tick <= 1'b0;
        end
    end
endmodule : baud_tick_gen
`default_nettype wire

// ### remote_tx_model.sv
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module remote_tx_model (
    input  wire logic mclk,
    output logic      rx_line
);
    initial rx_line = 1'b1;

    // Level changes only just after a clock edge
    task automatic hold(input logic level, input int cycles);
        @(posedge mclk) rx_line <= level;
        repeat (cycles - 1) @(posedge mclk);
    endtask : hold

    task automatic send_break(input int nbits, input int bit_cyc);
        hold(1'b0, nbits * bit_cyc);
        hold(1'b1, 2 * bit_cyc);
    endtask : send_break

    // Plain 8N1 character, LSB first; bit_cyc sets fast or slow links
    task automatic send_byte(input logic [7:0] data, input int bit_cyc);
        hold(1'b0, bit_cyc);
        for (int i = 0; i < 8; i++) hold(data[i], bit_cyc);
        hold(1'b1, bit_cyc);
    endtask : send_byte
endmodule : remote_tx_model
`default_nettype wire

// ### wake_uart.sv
// Asynchronous serial port with auto-wake on break and its registers
`timescale 1ns/1ps
`default_nettype none
`include "wake_uart_consts.svh"
module wake_uart (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       serial_rx_line,
    output logic            serial_tx_line,
    input  wire logic       sleep_mode,
    output logic            irq,
    output logic            wake_request
);
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_enables_one;
    logic [7:0] peripheral_irq_priority_one;
    logic [7:0] receive_status_control;
    logic [7:0] transmit_status_control;
    logic [7:0] baud_control;
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic [7:0] receive_data_register;
    logic [7:0] transmit_data;
    logic [3:0] ev_status;
    logic [3:0] ev_enable;
    logic       receive_irq_flag;
    logic       tx_pending;
    logic       rx_prev;
    logic       wake_seen;
    logic       wue_eff;
    logic       rx_fall;
    logic       rx_rise;
    logic       wake_set;
    logic       wake_done;
    logic       rx_enable;
    logic       rx_byte_done;
    logic       rx_frame_err;
    logic       tx_done;
    logic       tx_take;
    logic       rd_rx;
    logic       async_mode;
    logic [3:0] ev_set;
    logic [3:0] ovs_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift_rx;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic [7:0] shift_tx;
    wake_uart_pkg::rx_state_t rx_state;
    wake_uart_pkg::tx_state_t tx_state;

    baud_if bif ();

    assign bif.divisor = baud_control[`B_BRG16] ?
                         {baud_divisor_high, baud_divisor_low} :
                         {8'h00, baud_divisor_low};
    assign bif.run = !sleep_mode && receive_status_control[`B_SPEN];

    baud_tick_gen #(.WIDTH(16)) u_baud (
        .mclk    (mclk),
        .reset_n (reset_n),
        .bus     (bif.gen)
    );

    assign async_mode = receive_status_control[`B_SPEN] &&
                        !transmit_status_control[`B_SYNC];
    assign wue_eff    = baud_control[`B_WUE] && async_mode;
    assign rd_rx      = rd_en && (addr == `A_RX_DATA);
    assign rx_fall    = rx_prev && !serial_rx_line;
    assign rx_rise    = !rx_prev && serial_rx_line;
    assign wake_set   = wue_eff && !wake_seen && rx_fall;
    assign wake_done  = wue_eff && wake_seen && rx_rise;
    assign rx_enable  = async_mode && receive_status_control[`B_CREN] &&
                        !wue_eff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= serial_rx_line;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wake_seen <= 1'b0;
        end else if (!wue_eff || wake_done) begin
            wake_seen <= 1'b0;
        end else if (wake_set) begin
            wake_seen <= 1'b1;
        end
    end

    // Receiver, sampling mid-bit on the sixteen-times tick
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state     <= wake_uart_pkg::RX_IDLE;
            ovs_cnt      <= 4'h0;
            bit_cnt      <= 3'h0;
            shift_rx     <= `REG_RESET;
            rx_byte_done <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_byte_done <= 1'b0;
            rx_frame_err <= 1'b0;
            if (!rx_enable) begin
                rx_state <= wake_uart_pkg::RX_IDLE;
            end else if (bif.tick) begin
                ovs_cnt <= ovs_cnt + 4'h1;
                unique case (rx_state)
                    wake_uart_pkg::RX_IDLE: begin
                        ovs_cnt <= 4'h0;
                        if (!serial_rx_line) begin
                            rx_state <= wake_uart_pkg::RX_START;
                        end
                    end
                    wake_uart_pkg::RX_START: begin
                        if (ovs_cnt == `OVS_MID) begin
                            ovs_cnt  <= 4'h0;
                            bit_cnt  <= 3'h0;
                            rx_state <= serial_rx_line ?
                                        wake_uart_pkg::RX_IDLE :
                                        wake_uart_pkg::RX_DATA;
                        end
                    end
                    wake_uart_pkg::RX_DATA: begin
                        if (ovs_cnt == `OVS_LAST) begin
                            shift_rx <= {serial_rx_line, shift_rx[7:1]};
                            bit_cnt  <= bit_cnt + 3'h1;
                            if (bit_cnt == `BIT_LAST) begin
                                rx_state <= wake_uart_pkg::RX_STOP;
                            end
                        end
                    end
                    wake_uart_pkg::RX_STOP: begin
                        if (ovs_cnt == `OVS_LAST) begin
                            rx_byte_done <= 1'b1;
                            rx_frame_err <= !serial_rx_line;
                            rx_state     <= wake_uart_pkg::RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Transmitter, one byte buffered in transmit_data
    assign tx_take = tx_pending && (tx_state == wake_uart_pkg::TX_IDLE) &&
                     transmit_status_control[`B_TXEN] && async_mode;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state       <= wake_uart_pkg::TX_IDLE;
            tx_ovs         <= 4'h0;
            tx_bit         <= 3'h0;
            shift_tx       <= `REG_RESET;
            serial_tx_line <= 1'b1;
            tx_done        <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_take) begin
                shift_tx <= transmit_data;
                tx_ovs   <= 4'h0;
                tx_state <= wake_uart_pkg::TX_START;
            end else if (bif.tick) begin
                tx_ovs <= tx_ovs + 4'h1;
                unique case (tx_state)
                    wake_uart_pkg::TX_IDLE: begin
                        serial_tx_line <= 1'b1;
                    end
                    wake_uart_pkg::TX_START: begin
                        serial_tx_line <= 1'b0;
                        if (tx_ovs == `OVS_LAST) begin
                            tx_bit   <= 3'h0;
                            tx_state <= wake_uart_pkg::TX_DATA;
                        end
                    end
                    wake_uart_pkg::TX_DATA: begin
                        serial_tx_line <= shift_tx[0];
                        if (tx_ovs == `OVS_LAST) begin
                            shift_tx <= {1'b0, shift_tx[7:1]};
                            tx_bit   <= tx_bit + 3'h1;
                            if (tx_bit == `BIT_LAST) begin
                                tx_state <= wake_uart_pkg::TX_STOP;
                            end
                        end
                    end
                    wake_uart_pkg::TX_STOP: begin
                        serial_tx_line <= 1'b1;
                        if (tx_ovs == `OVS_LAST) begin
                            tx_done  <= 1'b1;
                            tx_state <= wake_uart_pkg::TX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pending    <= 1'b0;
            transmit_data <= `REG_RESET;
        end else if (wr_en && addr == `A_TX_DATA) begin
            tx_pending    <= 1'b1;
            transmit_data <= wdata;
        end else if (tx_take) begin
            tx_pending <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            receive_data_register <= `REG_RESET;
        end else if (rx_byte_done) begin
            receive_data_register <= shift_rx;
        end
    end

    // wake or a received byte sets the flag; read clears it, a set wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            receive_irq_flag <= 1'b0;
        end else if (wake_set || rx_byte_done) begin
            receive_irq_flag <= 1'b1;
        end else if (rd_rx) begin
            receive_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            receive_status_control <= `REG_RESET;
        end else if (wr_en && addr == `A_RX_STATUS) begin
            // Error set in the cycle of the clearing write still wins
            receive_status_control <= {wdata[7:3],
                                       rx_byte_done && rx_frame_err,
                                       rx_byte_done && receive_irq_flag,
                                       wdata[0]};
        end else begin
            // a low stop bit shows as framing error
            if (rx_byte_done) begin
                receive_status_control[`B_FERR] <= rx_frame_err;
            end
            if (rx_byte_done && receive_irq_flag && !rd_rx) begin
                receive_status_control[`B_OERR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            baud_control <= `REG_RESET;
        end else if (wr_en && addr == `A_BAUD_CONTROL) begin
            baud_control <= {2'b00, 1'b0, wdata[4:3], 1'b0,
                             wdata[1] && !wake_done, wdata[0]};
        end else if (wake_done) begin
            baud_control[`B_WUE] <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_control           <= `REG_RESET;
            peripheral_irq_enables_one  <= `REG_RESET;
            peripheral_irq_priority_one <= `REG_RESET;
            transmit_status_control     <= `REG_RESET;
            baud_divisor_high           <= `REG_RESET;
            baud_divisor_low            <= `REG_RESET;
            ev_enable                   <= 4'h0;
        end else if (wr_en) begin
            unique case (addr)
                `A_INT_CONTROL:  interrupt_control           <= wdata;
                `A_IRQ_ENABLES:  peripheral_irq_enables_one  <= wdata;
                `A_IRQ_PRIORITY: peripheral_irq_priority_one <= wdata;
                `A_TX_STATUS:    transmit_status_control     <= wdata;
                `A_DIV_HIGH:     baud_divisor_high           <= wdata;
                `A_DIV_LOW:      baud_divisor_low            <= wdata;
                `A_EV_ENABLE:    ev_enable                   <= wdata[3:0];
                default: ;
            endcase
        end
    end

    // Event flags; a new event wins over a clear in the same cycle
    always_comb begin
        ev_set              = 4'h0;
        ev_set[`EV_WAKE]    = wake_set;
        ev_set[`EV_RXDONE]  = rx_byte_done;
        ev_set[`EV_FERR]    = rx_byte_done && rx_frame_err;
        ev_set[`EV_TXDONE]  = tx_done;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ev_status <= 4'h0;
        end else if (wr_en && addr == `A_EV_CLEAR) begin
            ev_status <= (ev_status & ~wdata[3:0]) | ev_set;
        end else begin
            ev_status <= ev_status | ev_set;
        end
    end

    // line low while armed in sleep raises the request unclocked
    assign wake_request = wue_eff && !wake_seen && sleep_mode &&
                          !serial_rx_line;
    assign irq = (|(ev_status & ev_enable)) || wake_request;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= `REG_RESET;
        end else if (rd_en) begin
            unique case (addr)
                `A_INT_CONTROL:  rdata <= interrupt_control;
                `A_IRQ_FLAGS:    rdata <= {2'b00, receive_irq_flag,
                                           !tx_pending, 4'h0};
                `A_IRQ_ENABLES:  rdata <= peripheral_irq_enables_one;
                `A_IRQ_PRIORITY: rdata <= peripheral_irq_priority_one;
                `A_RX_STATUS:    rdata <= receive_status_control;
                `A_TX_STATUS:    rdata <= {transmit_status_control[7:2],
                                           tx_state == wake_uart_pkg::TX_IDLE
                                           && !tx_pending,
                                           transmit_status_control[0]};
                `A_BAUD_CONTROL: rdata <= {1'b0,
                    rx_state == wake_uart_pkg::RX_IDLE, baud_control[5:0]};
                `A_DIV_HIGH:     rdata <= baud_divisor_high;
                `A_DIV_LOW:      rdata <= baud_divisor_low;
                `A_RX_DATA:      rdata <= receive_data_register;
                `A_EV_STATUS:    rdata <= {4'h0, ev_status};
                `A_EV_ENABLE:    rdata <= {4'h0, ev_enable};
                default:         rdata <= `REG_RESET;
            endcase
        end else begin
            rdata <= `REG_RESET;
        end
    end

    sequence s_armed_fall;
        wue_eff && !wake_seen && rx_fall;
    endsequence

    sequence s_break_end;
        wue_eff && wake_seen && rx_rise;
    endsequence

    a_wue_arm_write: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_en && addr == `A_BAUD_CONTROL && wdata[`B_WUE] && !wake_done
        |=> baud_control[`B_WUE]) else $error("arm bit not set");
    a_rx_held_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        wue_eff [*2] |-> rx_state == wake_uart_pkg::RX_IDLE)
        else $error("receiver ran while armed");
    a_fall_sets_flag: assert property (@(posedge mclk) disable iff (!reset_n)
        s_armed_fall |=> receive_irq_flag && wake_seen)
        else $error("wake edge missed");
    a_flag_event_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        s_armed_fall |=> ev_status[`EV_WAKE])
        else $error("wake event not recorded");
    a_sleep_async_irq: assert property (@(posedge mclk) disable iff (!reset_n)
        wue_eff && !wake_seen && sleep_mode && !serial_rx_line |-> irq)
        else $error("no request in sleep");
    a_read_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_rx && !wake_set && !rx_byte_done |=> !receive_irq_flag)
        else $error("read left flag set");
    a_wue_self_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        s_armed_fall ##[1:1000] s_break_end |=> !baud_control[`B_WUE])
        else $error("arm bit stayed set");
    a_sleep_no_tick: assert property (@(posedge mclk) disable iff (!reset_n)
        sleep_mode |=> !bif.tick) else $error("tick in sleep");
    a_async_only: assert property (@(posedge mclk) disable iff (!reset_n)
        transmit_status_control[`B_SYNC] |-> !wue_eff && !wake_request)
        else $error("wake in sync mode");
    a_divisor_join: assert property (@(posedge mclk) disable iff (!reset_n)
        baud_control[`B_BRG16] |-> bif.divisor[15:8] == baud_divisor_high)
        else $error("divisor high byte lost");
endmodule : wake_uart
`default_nettype wire

// ### wake_uart_consts.svh
// Constants of the serial receiver with auto-wake on break
`ifndef WAKE_UART_CONSTS_SVH
`define WAKE_UART_CONSTS_SVH
`define A_INT_CONTROL   4'h0
`define A_IRQ_FLAGS     4'h1
`define A_IRQ_ENABLES   4'h2
`define A_IRQ_PRIORITY  4'h3
`define A_RX_STATUS     4'h4
`define A_TX_DATA       4'h5
`define A_TX_STATUS     4'h6
`define A_BAUD_CONTROL  4'h7
`define A_DIV_HIGH      4'h8
`define A_DIV_LOW       4'h9
`define A_RX_DATA       4'hA
`define A_EV_STATUS     4'hB
`define A_EV_CLEAR      4'hC
`define A_EV_ENABLE     4'hD
`define B_WUE           1
`define B_BRG16         3
`define B_RCIDL         6
`define B_SPEN          7
`define B_CREN          4
`define B_FERR          2
`define B_OERR          1
`define B_SYNC          4
`define B_TXEN          5
`define B_TRMT          1
`define B_RECEIVE_IRQ_FLAG          5
`define B_TXIF          4
`define B_GIE           7
`define B_PEIE          6
`define EV_WAKE         0
`define EV_RXDONE       1
`define EV_FERR         2
`define EV_TXDONE       3
`define OVS_LAST        4'hF
`define OVS_MID         4'h7
`define BIT_LAST        3'h7
`define REG_RESET       8'h00
`define DIV_RESET       16'h0000
`endif

// ### wake_uart_pkg.sv
// Types shared by the serial receiver modules
package wake_uart_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
endpackage : wake_uart_pkg

// ### wake_uart_tb.sv
// Self-checking bench for the serial port with auto-wake
`timescale 1ns/1ps
`default_nettype none
`include "wake_uart_consts.svh"
module wake_uart_tb;
    // Divisor 3 gives 16 ticks of 4 cycles per bit
    localparam int BITC = 64;
    logic       mclk;
    logic       reset_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rdata;
    logic       rx;
    logic       tx;
    logic       sleep_mode;
    logic       irq;
    logic       wake_request;
    int         err_count;
    int         compares;

    wake_uart wake_uart_inst (.mclk(mclk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .serial_rx_line(rx), .serial_tx_line(tx), .sleep_mode(sleep_mode),
        .irq(irq), .wake_request(wake_request));
    remote_tx_model remote_tx_model_inst (.mclk(mclk), .rx_line(rx));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] s, input logic [7:0] e,
                       input string m);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, m, s, e);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string s);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 chk(rdata & m, e, s);
    endtask : rc

    task automatic wait_irq(input logic lv, input int n);
        #1;
        for (int i = 0; i < n && irq !== lv; i++) begin
            @(posedge mclk);
            #1;
        end
        if (irq !== lv) begin
            err_count++;
            $display("CHECK FAILED at %0t: irq wait ran out", $time);
            conclude();
        end
    endtask : wait_irq

    task automatic t_regs();
        logic [3:0] ra [9] = '{`A_INT_CONTROL, `A_IRQ_ENABLES,
            `A_IRQ_PRIORITY, `A_RX_STATUS, `A_DIV_HIGH, `A_DIV_LOW,
            `A_EV_ENABLE, 4'hE, 4'hF};
        chk({7'h00, tx}, 8'h01, "tx idle");
        foreach (ra[i]) rc(ra[i], 8'hFF, `REG_RESET, "reset value");
        wr(`A_IRQ_PRIORITY, 8'hA5);
        rc(`A_IRQ_PRIORITY, 8'hFF, 8'hA5, "priority");
        wr(`A_DIV_HIGH, 8'h5A);
        wr(`A_DIV_LOW, 8'h03);
        rc(`A_DIV_HIGH, 8'hFF, 8'h5A, "divisor high");
        rc(`A_DIV_LOW, 8'hFF, 8'h03, "divisor low");
        wr(`A_EV_STATUS, 8'hFF);
        rc(`A_EV_STATUS, 8'hFF, 8'h00, "read-only status");
        wr(4'hE, 8'hFF);
        rc(4'hE, 8'hFF, 8'h00, "unmapped");
        $display("t_regs done");
    endtask : t_regs

    task automatic t_rx();
        wr(`A_RX_STATUS, 8'h90);
        wr(`A_EV_ENABLE, 8'h02);
        remote_tx_model_inst.send_byte(8'hC3, BITC);
        wait_irq(1'b1, 4 * BITC);
        rc(`A_IRQ_FLAGS, 8'h20, 8'h20, "rx flag");
        rc(`A_RX_DATA, 8'hFF, 8'hC3, "rx data");
        rc(`A_IRQ_FLAGS, 8'h20, 8'h00, "flag after read");
        wr(`A_EV_ENABLE, 8'h00);
        wait_irq(1'b0, 2);
        rc(`A_EV_STATUS, 8'h02, 8'h02, "rx event sticky");
        wr(`A_EV_CLEAR, 8'h02);
        rc(`A_EV_STATUS, 8'h02, 8'h00, "rx event cleared");
        $display("t_rx done");
    endtask : t_rx

    task automatic t_wake();
        wr(`A_EV_ENABLE, 8'h01);
        wr(`A_BAUD_CONTROL, 8'h02);
        rc(`A_BAUD_CONTROL, 8'h02, 8'h02, "armed");
        remote_tx_model_inst.hold(1'b0, 2);
        wait_irq(1'b1, 3);
        rc(`A_IRQ_FLAGS, 8'h20, 8'h20, "wake flag");
        rc(`A_BAUD_CONTROL, 8'h02, 8'h02, "armed while low");
        remote_tx_model_inst.send_break(12, BITC);
        rc(`A_BAUD_CONTROL, 8'h02, 8'h00, "self clear");
        rc(`A_EV_STATUS, 8'h07, 8'h01, "no character");
        rc(`A_RX_DATA, 8'hFF, 8'hC3, "dummy read keeps byte");
        rc(`A_IRQ_FLAGS, 8'h20, 8'h00, "wake flag clear");
        wr(`A_EV_CLEAR, 8'h01);
        wait_irq(1'b0, 2);
        $display("t_wake done");
    endtask : t_wake

    task automatic t_sleep();
        @(posedge mclk) sleep_mode <= 1'b1;
        wr(`A_BAUD_CONTROL, 8'h02);
        #1 chk({7'h00, wake_request}, 8'h00, "no request idle");
        remote_tx_model_inst.hold(1'b0, 1);
        #1 chk({7'h00, wake_request}, 8'h01, "wake request");
        chk({7'h00, irq}, 8'h01, "irq in sleep");
        remote_tx_model_inst.send_break(12, BITC);
        rc(`A_BAUD_CONTROL, 8'h02, 8'h00, "self clear asleep");
        rc(`A_EV_STATUS, 8'h01, 8'h01, "wake in sleep");
        rc(`A_RX_DATA, 8'hFF, 8'hC3, "dummy read asleep");
        wr(`A_EV_CLEAR, 8'h01);
        remote_tx_model_inst.send_byte(8'h55, BITC);
        rc(`A_EV_STATUS, 8'h02, 8'h00, "no rx in sleep");
        @(posedge mclk) sleep_mode <= 1'b0;
        $display("t_sleep done");
    endtask : t_sleep

    task automatic t_sync();
        wr(`A_TX_STATUS, 8'h10);
        wr(`A_BAUD_CONTROL, 8'h02);
        remote_tx_model_inst.hold(1'b0, 4);
        rc(`A_EV_STATUS, 8'h01, 8'h00, "no wake in sync");
        remote_tx_model_inst.hold(1'b1, 4);
        wr(`A_BAUD_CONTROL, 8'h00);
        wr(`A_TX_STATUS, 8'h00);
        $display("t_sync done");
    endtask : t_sync

    task automatic t_early();
        wr(`A_BAUD_CONTROL, 8'h02);
        remote_tx_model_inst.hold(1'b0, BITC);
        remote_tx_model_inst.hold(1'b1, 4);
        rc(`A_BAUD_CONTROL, 8'h02, 8'h00, "early rise ends");
        $display("t_early done");
    endtask : t_early

    task automatic t_tx();
        logic [7:0] got;
        int         n;
        got = 8'h00;
        wr(`A_TX_STATUS, 8'h20);
        wr(`A_TX_DATA, 8'hA6);
        #1;
        for (n = 0; n < 4 * BITC && tx !== 1'b0; n++) begin
            @(posedge mclk);
            #1;
        end
        if (tx !== 1'b0) begin
            err_count++;
            $display("CHECK FAILED at %0t: tx start wait ran out", $time);
            conclude();
        end
        // Sample each bit in its middle, 16 ticks apart
        repeat (BITC / 2) @(posedge mclk);
        #1 chk({7'h00, tx}, 8'h00, "tx start bit");
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge mclk);
            #1 got[i] = tx;
        end
        chk(got, 8'hA6, "tx data lsb first");
        repeat (BITC) @(posedge mclk);
        #1 chk({7'h00, tx}, 8'h01, "tx stop bit");
        repeat (BITC / 2) @(posedge mclk);
        rc(`A_EV_STATUS, 8'h08, 8'h08, "tx done event");
        rc(`A_TX_STATUS, 8'h02, 8'h02, "tx shift empty");
        wr(`A_TX_STATUS, 8'h00);
        $display("t_tx done");
    endtask : t_tx

    initial begin
        err_count = 0;
        compares = 0;
        reset_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        sleep_mode = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_rx();
        t_wake();
        t_sleep();
        t_sync();
        t_early();
        t_tx();
        conclude();
    end
endmodule : wake_uart_tb
`default_nettype wire
